/* logic/dars_pkg.sv */
// Package for the drive auto-restart supervisor: register map, defaults, states, carriers.
// Assumes a single 20 MHz clock and an AHB-Lite register bus with 32-bit data.
package dars_pkg;

	// Register byte offsets
	localparam logic [7:0] OFS_CTRL      = 8'h00;
	localparam logic [7:0] OFS_DRYDELAY  = 8'h04;
	localparam logic [7:0] OFS_RDELAY0   = 8'h08;
	localparam logic [7:0] OFS_LIMIT0    = 8'h14;
	localparam logic [7:0] OFS_STARTDLY  = 8'h2C;
	localparam logic [7:0] OFS_SHORTCYC  = 8'h30;
	localparam logic [7:0] OFS_SYSCFG    = 8'h34;
	localparam logic [7:0] OFS_PASSWORD  = 8'h38;
	localparam logic [7:0] OFS_ANASEL    = 8'h3C;
	localparam logic [7:0] OFS_UNLOCK    = 8'h40;
	localparam logic [7:0] OFS_STATUS    = 8'h44;
	localparam logic [7:0] OFS_COUNTDOWN = 8'h48;
	localparam logic [7:0] OFS_INTSTAT   = 8'h4C;
	localparam logic [7:0] OFS_INTMASK   = 8'h50;
	localparam logic [7:0] OFS_COUNT0    = 8'h54;

	// Control register fields
	localparam int CTRL_ENABLE = 0;
	localparam int CTRL_SKIP   = 1;
	localparam int CTRL_CLEAR  = 2;
	localparam int CTRL_FRESET = 3;

	// Restart counter classes
	localparam int NUM_CLASS   = 6;
	localparam int CL_OVERLOAD = 0;
	localparam int CL_DRYWELL  = 1;
	localparam int CL_UNDERV   = 2;
	localparam int CL_OVERV    = 3;
	localparam int CL_BUSOV    = 4;
	localparam int CL_SENSOR   = 5;
	localparam int NUM_DELAY   = 3;

	// Parameter limits and defaults, in seconds or counts
	localparam logic [13:0] MAX_LONG      = 14'd9999;
	localparam logic [13:0] MAX_SHORTCYC  = 14'd300;
	localparam logic [13:0] DEF_DRYDELAY  = 14'd4;
	localparam logic [13:0] DEF_RDELAY1   = 14'd60;
	localparam logic [13:0] DEF_RDELAY23  = 14'd15;
	localparam logic [13:0] DEF_LIM_OVL   = 14'd4;
	localparam logic [13:0] DEF_LIM_OTHER = 14'd10;
	localparam logic [13:0] DEF_STARTDLY  = 14'd0;
	localparam logic [13:0] DEF_SHORTCYC  = 14'd3;
	localparam logic [2:0]  MAX_SYSCFG    = 3'd4;
	localparam logic [6:0]  MAX_PASSWORD  = 7'd99;

	// Interrupt status bits
	localparam int INT_TRIP  = 0;
	localparam int INT_LOCK  = 1;
	localparam int INT_START = 2;
	localparam int NUM_INT   = 3;

	// Timebase
	localparam int CLOCK_HZ       = 20_000_000;
	localparam int SECOND_S       = 1;
	localparam int CYCLES_PER_SEC = CLOCK_HZ * SECOND_S;

	typedef enum logic [5:0] {
		ST_PWRUP = 6'b00_0001,
		ST_IDLE  = 6'b00_0010,
		ST_SCYC  = 6'b00_0100,
		ST_RUN   = 6'b00_1000,
		ST_RDLY  = 6'b01_0000,
		ST_LOCK  = 6'b10_0000
	} dars_state_t;

	typedef struct packed {
		logic overload;
		logic busOver;
		logic dryWell;
		logic unbalance;
		logic sensorLoss;
		logic hallSense;
		logic underVolt;
		logic overVolt;
	} dars_fault_t;

	typedef struct packed {
		logic runExternal;
		logic runInputOne;
		logic runInputTwo;
		logic keyRun;
		logic keyAuto;
		logic keyOff;
		logic keyUp;
		logic keyDown;
		logic keyClear;
	} dars_keys_t;

	typedef struct packed {
		logic constPressure;
		logic speedVoltage;
		logic speedCurrent;
		logic loopHandOffAuto;
	} dars_cfg_t;

endpackage : dars_pkg

/* logic/dars_supervisor.sv */
// Drive auto-restart supervisor: fault retry, start delays, keypad lock and setting decode.
// Assumes fault, run and key pins are asynchronous levels; AHB-Lite slave with one master.
//
// Local design decisions: the AHB-Lite interface to the registers and the placing of the registers.
`timescale 1ns/10ps

module dars_supervisor
	import dars_pkg::*;
#(
	parameter int CyclesPerSec = CYCLES_PER_SEC
) (
	input  wire logic        clock,
	input  wire logic        rstn,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic      [31:0] hrdata,
	output logic             hresp,
	input  wire dars_fault_t faultIn,
	input  wire dars_keys_t  keysIn,
	output logic             motorRun,
	output logic             autoMode,
	output logic             tripped,
	output logic      [13:0] countdown,
	output dars_cfg_t        cfgMode,
	output logic      [1:0]  analogPrimary,
	output logic             analogBackup,
	output logic             keypadLocked,
	output logic             irq
);

	if (CyclesPerSec < 2) begin : g_rateCheck
		$error("CyclesPerSec must be at least 2");
	end

	localparam int SYNC_W = $bits(dars_fault_t) + $bits(dars_keys_t);

	// Two-flop synchronisers; only the second stage is read
	logic [SYNC_W-1:0] syncA_reg;
	logic [SYNC_W-1:0] syncB_reg;
	dars_fault_t       flt;
	dars_keys_t        keys;
	dars_keys_t        keysPrev_reg;

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			syncA_reg    <= '0;
			syncB_reg    <= '0;
			keysPrev_reg <= '0;
		end else begin
			syncA_reg    <= {faultIn, keysIn};
			syncB_reg    <= syncA_reg;
			keysPrev_reg <= keys;
		end
	end

	assign flt  = dars_fault_t'(syncB_reg[SYNC_W-1 -: $bits(dars_fault_t)]);
	assign keys = dars_keys_t'(syncB_reg[$bits(dars_keys_t)-1:0]);

	logic keyRunEdge;
	logic keyAutoEdge;
	logic keyOffEdge;
	logic keyClearEdge;
	logic abortKeys;

	assign keyRunEdge   = keys.keyRun & ~keysPrev_reg.keyRun;
	assign keyAutoEdge  = keys.keyAuto & ~keysPrev_reg.keyAuto;
	assign keyOffEdge   = keys.keyOff & ~keysPrev_reg.keyOff;
	assign keyClearEdge = keys.keyClear & ~keysPrev_reg.keyClear;
	assign abortKeys    = keys.keyUp & keys.keyDown & ~(keysPrev_reg.keyUp & keysPrev_reg.keyDown);

	// Seconds timebase
	logic [31:0] preCnt_reg;
	logic        secTick;

	assign secTick = (preCnt_reg == 32'(CyclesPerSec - 1));

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			preCnt_reg <= '0;
		end else begin
			preCnt_reg <= secTick ? 32'h0000_0000 : preCnt_reg + 32'h0000_0001;
		end
	end

	// AHB-Lite address phase capture; always zero wait states, always OKAY
	logic       wrPend_reg;
	logic [7:0] wrAddr_reg;
	logic       accept;

	assign accept = hsel & hready & htrans[1];

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			wrPend_reg <= 1'b0;
			wrAddr_reg <= '0;
			hreadyout  <= 1'b1;
			hresp      <= 1'b0;
		end else begin
			wrPend_reg <= accept & hwrite & (hsize == 3'd2);
			wrAddr_reg <= haddr[7:0];
			hreadyout  <= 1'b1;
			hresp      <= 1'b0;
		end
	end

	// Settings
	logic             enable_reg;
	logic [13:0]      dryDelay_reg;
	logic [13:0]      rDelay_reg [NUM_DELAY];
	logic [13:0]      limit_reg [NUM_CLASS];
	logic [13:0]      startDly_reg;
	logic [13:0]      shortCyc_reg;
	logic [2:0]       sysCfg_reg;
	logic [6:0]       password_reg;
	logic [1:0]       anaSel_reg;
	logic             unlocked_reg;
	logic [NUM_INT-1:0] intMask_reg;
	logic             locked;
	logic             wrOk;
	logic [13:0]      wVal;

	function automatic logic isOfs(input logic [7:0] a, input logic [7:0] base, input int idx);
		return a == 8'(base + 8'(idx * 4));
	endfunction : isOfs

	assign locked = (password_reg != 7'd0) & ~unlocked_reg;
	assign wrOk   = wrPend_reg & ~locked;
	assign wVal   = hwdata[13:0];

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			enable_reg   <= 1'b1;
			dryDelay_reg <= DEF_DRYDELAY;
			rDelay_reg   <= '{DEF_RDELAY1, DEF_RDELAY23, DEF_RDELAY23};
			limit_reg    <= '{DEF_LIM_OVL, DEF_LIM_OTHER, DEF_LIM_OTHER,
			                  DEF_LIM_OTHER, DEF_LIM_OTHER, DEF_LIM_OTHER};
			startDly_reg <= DEF_STARTDLY;
			shortCyc_reg <= DEF_SHORTCYC;
			sysCfg_reg   <= '0;
			password_reg <= '0;
			anaSel_reg   <= '0;
			intMask_reg  <= '0;
		end else if (wrOk) begin
			// Out-of-range values are dropped so a setting never leaves its range
			if (isOfs(wrAddr_reg, OFS_CTRL, 0)) begin
				enable_reg <= hwdata[CTRL_ENABLE];
			end
			if (isOfs(wrAddr_reg, OFS_DRYDELAY, 0) && wVal <= MAX_LONG && hwdata[31:14] == '0) begin
				dryDelay_reg <= wVal;
			end
			for (int i = 0; i < NUM_DELAY; i++) begin
				if (isOfs(wrAddr_reg, OFS_RDELAY0, i) && wVal <= MAX_LONG && hwdata[31:14] == '0) begin
					rDelay_reg[i] <= wVal;
				end
			end
			for (int i = 0; i < NUM_CLASS; i++) begin
				if (isOfs(wrAddr_reg, OFS_LIMIT0, i) && wVal <= MAX_LONG && hwdata[31:14] == '0) begin
					limit_reg[i] <= wVal;
				end
			end
			if (isOfs(wrAddr_reg, OFS_STARTDLY, 0) && wVal <= MAX_LONG && hwdata[31:14] == '0) begin
				startDly_reg <= wVal;
			end
			if (isOfs(wrAddr_reg, OFS_SHORTCYC, 0) && wVal <= MAX_SHORTCYC
			    && hwdata[31:14] == '0) begin
				shortCyc_reg <= wVal;
			end
			if (isOfs(wrAddr_reg, OFS_SYSCFG, 0) && hwdata[31:3] == '0
			    && hwdata[2:0] <= MAX_SYSCFG) begin
				sysCfg_reg <= hwdata[2:0];
			end
			if (isOfs(wrAddr_reg, OFS_PASSWORD, 0) && hwdata[31:7] == '0
			    && hwdata[6:0] <= MAX_PASSWORD) begin
				password_reg <= hwdata[6:0];
			end
			if (isOfs(wrAddr_reg, OFS_ANASEL, 0) && hwdata[31:2] == '0) begin
				anaSel_reg <= hwdata[1:0];
			end
			if (isOfs(wrAddr_reg, OFS_INTMASK, 0)) begin
				intMask_reg <= hwdata[NUM_INT-1:0];
			end
		end
	end

	// Unlock: writing the password opens the keypad; any other value closes it
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			unlocked_reg <= 1'b0;
		end else if (wrPend_reg && isOfs(wrAddr_reg, OFS_UNLOCK, 0)) begin
			unlocked_reg <= (hwdata[6:0] == password_reg) && (hwdata[31:7] == '0);
		end
	end

	// Command pulses from the control register; skip and clear also come from the keypad keys
	logic ctrlWr;
	logic skipCmd;
	logic clearCmd;
	logic fResetCmd;

	assign ctrlWr    = wrOk & isOfs(wrAddr_reg, OFS_CTRL, 0);
	assign skipCmd   = abortKeys | (ctrlWr & hwdata[CTRL_SKIP]);
	assign clearCmd  = keyClearEdge | (ctrlWr & hwdata[CTRL_CLEAR]);
	assign fResetCmd = ctrlWr & hwdata[CTRL_FRESET];

	// Run request per mode
	dars_state_t state_reg;
	logic manual_reg;
	logic extOk;
	logic runReq;

	assign extOk  = (sysCfg_reg == 3'd0) ? (keys.runInputOne & keys.runInputTwo)
	                                     : keys.runExternal;
	assign runReq = autoMode ? extOk : manual_reg;

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			manual_reg <= 1'b0;
			autoMode   <= 1'b0;
		end else if (state_reg == ST_PWRUP) begin
			autoMode   <= enable_reg;
			manual_reg <= 1'b0;
		end else if (keyOffEdge) begin
			autoMode   <= 1'b0;
			manual_reg <= 1'b0;
		end else if (keyRunEdge) begin
			autoMode   <= 1'b0;
			manual_reg <= 1'b1;
		end else if (keyAutoEdge) begin
			autoMode   <= 1'b1;
			manual_reg <= 1'b0;
		end
	end

	// Fault classification: immediate faults, dry well after persistence
	logic [13:0] dryCnt_reg;
	logic        dryTrip;
	logic        trip;
	logic [1:0]  tripDelaySel;
	logic [2:0]  tripClass;
	logic        tripLimited;

	assign dryTrip = flt.dryWell & (dryCnt_reg >= dryDelay_reg);

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			dryCnt_reg <= '0;
		end else if (!flt.dryWell || state_reg != ST_RUN) begin
			dryCnt_reg <= '0;
		end else if (secTick && dryCnt_reg != MAX_LONG) begin
			dryCnt_reg <= dryCnt_reg + 14'd1;
		end
	end

	always_comb begin
		trip         = 1'b1;
		tripDelaySel = 2'd1;
		tripClass    = 3'(CL_OVERLOAD);
		tripLimited  = 1'b1;
		if (flt.overload) begin
			tripDelaySel = 2'd0;
			tripClass    = 3'(CL_OVERLOAD);
		end else if (flt.busOver) begin
			tripClass = 3'(CL_BUSOV);
		end else if (dryTrip) begin
			tripClass = 3'(CL_DRYWELL);
		end else if (flt.sensorLoss) begin
			tripClass = 3'(CL_SENSOR);
		end else if (flt.unbalance) begin
			tripLimited = 1'b0;
		end else if (flt.underVolt) begin
			tripDelaySel = 2'd2;
			tripClass    = 3'(CL_UNDERV);
		end else if (flt.overVolt) begin
			tripDelaySel = 2'd2;
			tripClass    = 3'(CL_OVERV);
		end else if (flt.hallSense) begin
			tripDelaySel = 2'd2;
			tripLimited  = 1'b0;
		end else begin
			trip        = 1'b0;
			tripLimited = 1'b0;
		end
	end

	// Restart counters; unbalance and hall trips retry without a count
	logic [13:0] count_reg [NUM_CLASS];
	logic        exhausted;
	logic        toRestart;

	assign exhausted = tripLimited & (count_reg[tripClass] >= limit_reg[tripClass]);
	assign toRestart = (state_reg == ST_RUN) & trip & enable_reg & ~exhausted;

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			count_reg <= '{default: '0};
		end else if (clearCmd) begin
			count_reg <= '{default: '0};
		end else if (toRestart && tripLimited) begin
			count_reg[tripClass] <= count_reg[tripClass] + 14'd1;
		end
	end

	// Sequencer
	logic cdDone;

	assign cdDone = (countdown == 14'd0) | skipCmd;

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			state_reg <= ST_PWRUP;
			countdown <= DEF_STARTDLY;
		end else begin
			if (secTick && countdown != 14'd0) begin
				countdown <= countdown - 14'd1;
			end
			unique case (state_reg)
				ST_PWRUP: begin
					if (cdDone) begin
						state_reg <= ST_IDLE;
						countdown <= '0;
					end
				end
				ST_IDLE: begin
					if (runReq) begin
						state_reg <= ST_SCYC;
						countdown <= shortCyc_reg;
					end
				end
				ST_SCYC: begin
					if (!runReq) begin
						state_reg <= ST_IDLE;
						countdown <= '0;
					end else if (cdDone) begin
						state_reg <= ST_RUN;
						countdown <= '0;
					end
				end
				ST_RUN: begin
					if (trip && toRestart) begin
						state_reg <= ST_RDLY;
						countdown <= rDelay_reg[tripDelaySel];
					end else if (trip) begin
						state_reg <= ST_LOCK;
					end else if (!runReq) begin
						state_reg <= ST_IDLE;
					end
				end
				ST_RDLY: begin
					if (cdDone) begin
						state_reg <= ST_IDLE;
						countdown <= '0;
					end
				end
				ST_LOCK: begin
					if (clearCmd || fResetCmd) begin
						state_reg <= ST_IDLE;
					end
				end
			endcase
		end
	end

	// Status outputs and decode
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			motorRun      <= 1'b0;
			tripped       <= 1'b0;
			cfgMode       <= '0;
			analogPrimary <= 2'd1;
			analogBackup  <= 1'b0;
			keypadLocked  <= 1'b0;
		end else begin
			motorRun      <= (state_reg == ST_RUN) & ~trip & runReq;
			tripped       <= (state_reg == ST_RDLY) | (state_reg == ST_LOCK);
			cfgMode       <= '{constPressure:   sysCfg_reg == 3'd1,
			                   speedVoltage:    sysCfg_reg == 3'd2,
			                   speedCurrent:    sysCfg_reg == 3'd3,
			                   loopHandOffAuto: sysCfg_reg == 3'd4};
			analogPrimary <= anaSel_reg[0] ? 2'd2 : 2'd1;
			analogBackup  <= anaSel_reg[1];
			keypadLocked  <= locked;
		end
	end

	// Interrupt status, cleared by a read; a new event wins over the clear
	logic [NUM_INT-1:0] intStat_reg;
	logic [NUM_INT-1:0] intEvent;
	logic               rdStat;

	assign intEvent[INT_TRIP]  = (state_reg == ST_RUN) & trip;
	assign intEvent[INT_LOCK]  = (state_reg == ST_RUN) & trip & ~toRestart;
	assign intEvent[INT_START] = (state_reg == ST_SCYC) & runReq & cdDone;
	assign rdStat = accept & ~hwrite & (haddr[7:0] == OFS_INTSTAT);

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			intStat_reg <= '0;
			irq         <= 1'b0;
		end else begin
			intStat_reg <= (rdStat ? '0 : intStat_reg) | intEvent;
			irq         <= |(((rdStat ? '0 : intStat_reg) | intEvent) & intMask_reg);
		end
	end

	// Read data registered at the address phase edge
	logic [31:0] rdMux;

	always_comb begin
		rdMux = '0;
		if (isOfs(haddr[7:0], OFS_CTRL, 0))      rdMux = {31'd0, enable_reg};
		if (isOfs(haddr[7:0], OFS_DRYDELAY, 0))  rdMux = {18'd0, dryDelay_reg};
		for (int i = 0; i < NUM_DELAY; i++) begin
			if (isOfs(haddr[7:0], OFS_RDELAY0, i)) rdMux = {18'd0, rDelay_reg[i]};
		end
		for (int i = 0; i < NUM_CLASS; i++) begin
			if (isOfs(haddr[7:0], OFS_LIMIT0, i)) rdMux = {18'd0, limit_reg[i]};
			if (isOfs(haddr[7:0], OFS_COUNT0, i)) rdMux = {18'd0, count_reg[i]};
		end
		if (isOfs(haddr[7:0], OFS_STARTDLY, 0))  rdMux = {18'd0, startDly_reg};
		if (isOfs(haddr[7:0], OFS_SHORTCYC, 0))  rdMux = {18'd0, shortCyc_reg};
		if (isOfs(haddr[7:0], OFS_SYSCFG, 0))    rdMux = {29'd0, sysCfg_reg};
		if (isOfs(haddr[7:0], OFS_PASSWORD, 0))  rdMux = {25'd0, password_reg};
		if (isOfs(haddr[7:0], OFS_ANASEL, 0))    rdMux = {30'd0, anaSel_reg};
		if (isOfs(haddr[7:0], OFS_STATUS, 0))    rdMux = {24'd0, locked, autoMode, state_reg};
		if (isOfs(haddr[7:0], OFS_COUNTDOWN, 0)) rdMux = {18'd0, countdown};
		if (isOfs(haddr[7:0], OFS_INTSTAT, 0))   rdMux = {29'd0, intStat_reg};
		if (isOfs(haddr[7:0], OFS_INTMASK, 0))   rdMux = {29'd0, intMask_reg};
		if (haddr[31:8] != '0)                   rdMux = '0;
	end

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			hrdata <= '0;
		end else if (accept && !hwrite) begin
			hrdata <= rdMux;
		end
	end

endmodule : dars_supervisor

/* verif/dars_partner.sv */
// Far-side model: fault detectors and keypad feeding the supervisor.
// Assumes the bench sets the requests just after a rising clock edge.
`timescale 1ns/10ps

module dars_partner
	import dars_pkg::*;
(
	input  wire logic        clock,
	input  wire logic        rstn,
	input  wire dars_fault_t faultReq,
	input  wire dars_keys_t  keyReq,
	input  wire logic        motorRun,
	output dars_fault_t      faultIn,
	output dars_keys_t       keysIn
);
	// Current-based detectors see nothing while the motor is stopped
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			faultIn <= '0;
		end else begin
			faultIn <= motorRun ? faultReq : (faultReq & 8'h4B);
		end
	end

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			keysIn <= '0;
		end else begin
			keysIn <= keyReq;
		end
	end
endmodule : dars_partner

/* verif/dars_monitor.sv */
// Checker on the supervisor's ports.
// Assumes one clock domain with the asynchronous active-low reset.
`timescale 1ns/10ps

module dars_monitor
	import dars_pkg::*;
#(
	parameter int CyclesPerSec = CYCLES_PER_SEC
) (
	input  wire logic        clock,
	input  wire logic        rstn,
	input  wire logic        hreadyout,
	input  wire logic        hresp,
	input  wire dars_keys_t  keysIn,
	input  wire logic        motorRun,
	input  wire logic        tripped,
	input  wire logic [13:0] countdown,
	input  wire dars_cfg_t   cfgMode,
	input  wire logic [1:0]  analogPrimary
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rstn);

	// Sync and register latency stay well inside six cycles
	sequence s_inputOpen;
		(cfgMode == 4'h0 && !(keysIn.runInputOne && keysIn.runInputTwo))[*6];
	endsequence
	sequence s_runStart;
		!motorRun ##1 motorRun;
	endsequence

	property p_ready;
		hreadyout && !hresp;
	endproperty
	a_ready: assert property (p_ready) else $error("bus not ready or not okay");
	property p_tripNoRun;
		tripped |-> !motorRun;
	endproperty
	a_tripNoRun: assert property (p_tripNoRun) else $error("motor runs while tripped");
	property p_cfgOnehot;
		$onehot0(cfgMode);
	endproperty
	a_cfgOnehot: assert property (p_cfgOnehot) else $error("config decode not one-hot");
	property p_anaPrim;
		analogPrimary == 2'h1 || analogPrimary == 2'h2;
	endproperty
	a_anaPrim: assert property (p_anaPrim) else $error("bad primary input");
	property p_cdMax;
		countdown <= 14'h270F;
	endproperty
	a_cdMax: assert property (p_cdMax) else $error("countdown above range");
	property p_cdStep;
		countdown < $past(countdown) |->
			countdown == $past(countdown) - 14'h0001 || countdown == 14'h0000;
	endproperty
	a_cdStep: assert property (p_cdStep) else $error("countdown skipped a second");
	property p_cfg0Stop;
		s_inputOpen |-> !motorRun;
	endproperty
	a_cfg0Stop: assert property (p_cfg0Stop) else $error("runs without both inputs");
	property p_runStart;
		s_runStart |-> countdown == 14'h0000 && !tripped;
	endproperty
	a_runStart: assert property (p_runStart) else $error("run before delay expired");
endmodule : dars_monitor

bind dars_supervisor dars_monitor #(.CyclesPerSec(CyclesPerSec)) u_mon (
	.clock(clock), .rstn(rstn), .hreadyout(hreadyout), .hresp(hresp), .keysIn(keysIn),
	.motorRun(motorRun), .tripped(tripped), .countdown(countdown), .cfgMode(cfgMode),
	.analogPrimary(analogPrimary));

/* verif/testbench.sv */
// Self-checking bench for the supervisor with a register model.
// Assumes a ten-cycle second so delays stay short.
`timescale 1ns/10ps

module testbench;
	import dars_pkg::*;
	logic        clock, rstn, hsel, hwrite, hreadyout, hresp, motorRun, autoMode, tripped;
	logic        keypadLocked, irq, analogBackup;
	logic [31:0] haddr, hwdata, hrdata, r;
	logic [1:0]  htrans, analogPrimary;
	logic [2:0]  hsize;
	logic [13:0] countdown, mx;
	dars_cfg_t   cfgMode;
	dars_fault_t faultReq, faultIn;
	dars_keys_t  keyReq, keysIn;
	int          n_mismatch, samples_checked, cyc, n, pw;
	int          seed = 32'h244d;
	int          mdl[16] = '{0, 4, 60, 15, 15, 4, 10, 10, 10, 10, 10, 0, 3, 0, 0, 0};
	int          lim[16] = '{15, 9999, 9999, 9999, 9999, 9999, 9999, 9999, 9999, 9999,
	                         9999, 9999, 300, 4, 99, 3};
	bit          unl;

	dars_supervisor #(.CyclesPerSec(10)) dut (.clock(clock), .rstn(rstn), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
		.faultIn(faultIn), .keysIn(keysIn), .motorRun(motorRun), .autoMode(autoMode),
		.tripped(tripped), .countdown(countdown), .cfgMode(cfgMode),
		.analogPrimary(analogPrimary), .analogBackup(analogBackup),
		.keypadLocked(keypadLocked), .irq(irq));
	dars_partner u_far (.clock(clock), .rstn(rstn), .faultReq(faultReq), .keyReq(keyReq),
		.motorRun(motorRun), .faultIn(faultIn), .keysIn(keysIn));

	always #25 clock = ~clock;

	task automatic test_done();
		$display("checks %0d mismatches %0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : test_done

	// Stalls are allowed; only the cycle ceiling ends a hung wait
	always @(posedge clock) begin
		cyc++;
		if (cyc == 30000) begin
			n_mismatch++;
			test_done();
		end
	end

	task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
		samples_checked++;
		if (s !== e) begin
			n_mismatch++;
			$display("BAD %s expected %0h seen %0h", nm, e, s);
		end
	endtask : chk

	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clock);
		hsel   <= 1'b1;
		htrans <= 2'b10;
		haddr  <= {24'h00_0000, a};
		hwrite <= w;
		do @(posedge clock); while (hreadyout !== 1'b1);
		htrans <= 2'b00;
		hwdata <= d;
		do @(posedge clock); while (hreadyout !== 1'b1);
		r = hrdata;
	endtask : bus

	// Model keeps the old value on a locked or out-of-range write
	task automatic wr(input logic [7:0] a, input int d);
		bus(1'b1, a, d);
		if (a == 8'h40) unl = (d == mdl[14]);
		else if (a < 8'h40 && !(mdl[14] != 0 && !unl) && d <= lim[a >> 2]) mdl[a >> 2] = d;
	endtask : wr

	task automatic rchk(input string nm, input logic [7:0] a, input int e);
		bus(1'b0, a, 32'h0000_0000);
		chk(nm, r, e);
	endtask : rchk

	task automatic waitv(ref logic s, input logic v, input int bound);
		n = 0;
		while (s !== v && n < bound) begin
			@(negedge clock);
			n++;
			if (countdown > mx) mx = countdown;
		end
	endtask : waitv

	task automatic trip();
		faultReq.overload <= 1'b1;
		waitv(tripped, 1'b1, 40);
		faultReq.overload <= 1'b0;
	endtask : trip

	initial begin
		clock = 1'b0; rstn = 1'b0; hsel = 1'b0; haddr = '0; htrans = 2'b00; hwrite = 1'b0;
		hsize = 3'h2; hwdata = '0; faultReq = '0; keyReq = '0; mx = '0;
		repeat (20) @(posedge clock);
		rstn <= 1'b1;
		for (int i = 1; i < 16; i++) rchk("default", 8'(i * 4), mdl[i]);
		rchk("unmapped", 8'h80, 0);
		chk("autoMode", autoMode, 1'b1);
		$display("test defaults done");
		// Decode outputs follow the setting register by one more edge
		for (int c = 0; c < 6; c++) begin
			wr(8'h34, c);
			repeat (2) @(negedge clock);
			chk("cfgMode", cfgMode, mdl[13] == 0 ? 0 : 1 << (4 - mdl[13]));
		end
		for (int a = 0; a < 5; a++) begin
			wr(8'h3C, a);
			repeat (2) @(negedge clock);
			chk("analogPrimary", analogPrimary, mdl[15] % 2 + 1);
			chk("analogBackup", analogBackup, mdl[15] >= 2);
		end
		wr(8'h34, 0);
		$display("test decode done");
		pw = {$random(seed)} % 99 + 1;
		wr(8'h38, pw);
		wr(8'h30, 9);
		rchk("lockedWrite", 8'h30, mdl[12]);
		chk("keypadLocked", keypadLocked, 1'b1);
		wr(8'h40, pw);
		wr(8'h38, 0);
		@(negedge clock);
		chk("keypadLocked", keypadLocked, 1'b0);
		$display("test password done");
		wr(8'h30, 2);
		wr(8'h08, 2);
		wr(8'h14, 1);
		wr(8'h50, 7);
		keyReq.runInputOne <= 1'b1;
		keyReq.runInputTwo <= 1'b1;
		waitv(motorRun, 1'b1, 100);
		chk("shortCycle", n >= 10 && n <= 40, 1'b1);
		chk("countdownShown", mx, 2);
		@(posedge clock);
		keyReq.runInputTwo <= 1'b0;
		waitv(motorRun, 1'b0, 20);
		chk("inputStop", n <= 8, 1'b1);
		keyReq.runInputTwo <= 1'b1;
		waitv(motorRun, 1'b1, 100);
		$display("test short cycle done");
		trip();
		chk("tripStop", motorRun, 1'b0);
		rchk("count0", 8'h54, 1);
		waitv(tripped, 1'b0, 100);
		chk("restartDelay", n >= 5 && n <= 30, 1'b1);
		waitv(motorRun, 1'b1, 100);
		trip();
		repeat (60) @(negedge clock);
		chk("lockout", tripped, 1'b1);
		chk("irq", irq, 1'b1);
		rchk("intStatus", 8'h4C, 7);
		rchk("intCleared", 8'h4C, 0);
		chk("irq", irq, 1'b0);
		wr(8'h00, 5);
		rchk("count0", 8'h54, 0);
		waitv(tripped, 1'b0, 40);
		chk("released", tripped, 1'b0);
		$display("test limit done");
		waitv(motorRun, 1'b1, 100);
		wr(8'h08, 500);
		trip();
		repeat (15) @(negedge clock);
		chk("countdown", countdown >= 14'd498 && countdown <= 14'd500, 1'b1);
		@(posedge clock);
		keyReq.keyUp   <= 1'b1;
		keyReq.keyDown <= 1'b1;
		repeat (6) @(posedge clock);
		keyReq.keyUp   <= 1'b0;
		keyReq.keyDown <= 1'b0;
		waitv(tripped, 1'b0, 30);
		chk("skip", tripped, 1'b0);
		$display("test skip done");
		waitv(motorRun, 1'b1, 100);
		// Two seconds of dry well must pass before the trip
		wr(8'h04, 2);
		faultReq.dryWell <= 1'b1;
		waitv(tripped, 1'b1, 60);
		faultReq.dryWell <= 1'b0;
		chk("dryPersist", n >= 10 && n <= 40, 1'b1);
		rchk("count1", 8'h58, 1);
		$display("test dry well done");
		waitv(motorRun, 1'b1, 300);
		wr(8'h00, 0);
		trip();
		repeat (100) @(negedge clock);
		chk("noRetry", tripped, 1'b1);
		chk("noRun", motorRun, 1'b0);
		keyReq.keyOff <= 1'b1;
		repeat (6) @(negedge clock);
		chk("keyOff", autoMode, 1'b0);
		$display("test disabled done");
		test_done();
	end
endmodule : testbench
